// ===== vgafb_access.sv
// Purpose: Graphics-controller frame-buffer access and address mapping
// Assumes: Host I/O and memory cycles are single-cycle strobes on clk_sys
// Notes: Plane read data arrives in the same cycle as the read strobe
//
// How it works
// - Odd/even mode sends even addresses to planes 0,2, odd to 1,3.
// - Read mode 0 returns the plane chosen by the read plane field; in odd/even, A0 picks the plane within the pair that field selects.
// - Read mode 1 returns per-bit colour match across included planes.
// - Write mode 0 writes rotated data, or set/reset where enabled.
// - Write mode 1 copies the read latches into each plane enabled by the write mask and, in odd/even, by A0.
// - Every planar frame-buffer read reloads the four read latches.
// - Write mode 2 expands the low data nibble as colour under mask.
// - Write mode 3 uses data AND bit mask to write set/reset.
// - Memory map field picks which host window is decoded.
// - Chain odd/even drops A0 and puts a high address bit on top.
// - Colour don't-care bits include planes in the read mode 1 compare.
// - Bit mask zero keeps latch bits in every plane on every write.
// - Paging forms internal address from page bits above host address.
// - Local-memory bit redirects paging only under its enabling modes.
// - Packed mode forces packed-pixel translation, map field picks memory.
// - Zero mapping bits use VGA translation; else only A0 range pages.
// - Legacy accesses need no translation table and never prefetch.
// - Page selector picks a 64KB window and pages register addresses.
// - Indexes 14h to 1Fh are scratch bytes reset to zero.
// - Reserved upper bits of misc and don't-care registers read zero.
`timescale 1ns/1ps
module vgafb_access
#(
  parameter int PLANE_ADDR_W = 16,
  parameter int EXT_ADDR_W = 23
)
(
  input wire logic clk_sys,
  input wire logic srst,
  // Indexed register port
  input wire logic idx_wr,
  input wire logic [7:0] idx_wdata,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic [7:0] idx_rdata,
  // Host frame-buffer cycles
  input wire vgafb_pkg::vgafb_req_t fb_req,
  output logic fb_hit,
  output logic [7:0] fb_rdata,
  // Four planes behind
  output logic [PLANE_ADDR_W-1:0] plane_addr,
  output logic plane_rd,
  output vgafb_pkg::vgafb_pwr_t plane_wr,
  input wire logic [31:0] plane_rdata,
  // Translated path bypassing the planes
  output logic bypass_valid,
  output logic bypass_wr,
  output logic bypass_local,
  output logic [EXT_ADDR_W-1:0] bypass_addr,
  output logic bypass_prefetch,
  output logic bypass_need_table,
  // Plane write mask from the sequencer
  input wire logic [3:0] plane_write_mask,
  output logic [7:0] mmio_page
);
  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  logic [7:0] index_ff;
  logic [7:0] set_reset_value_ff, set_reset_enable_ff, compare_colour_ff;
  logic [7:0] rotate_count_ff, read_plane_choice_ff;
  logic [7:0] rw_mode_reg_ff, misc_map_reg_ff, compare_ignore_reg_ff;
  logic [7:0] write_mask_reg_ff, ext_mapping_reg_ff, page_select_reg_ff;
  logic [7:0] scratch_ff [vgafb_pkg::SCRATCH_COUNT];
  logic [31:0] latch_ff;
  logic [7:0] fb_rdata_ff;
  logic fb_hit_ff;

  wire is_scratch = (index_ff >= vgafb_pkg::IDX_SCRATCH_FIRST)
                    && (index_ff <= vgafb_pkg::IDX_SCRATCH_LAST);
  wire [7:0] scratch_ofs = index_ff - vgafb_pkg::IDX_SCRATCH_FIRST;
  wire [3:0] scratch_sel = scratch_ofs[3:0];

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      index_ff <= vgafb_pkg::RST_ZERO;
    else if (idx_wr)
      index_ff <= idx_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      set_reset_value_ff <= vgafb_pkg::RST_ZERO;
      set_reset_enable_ff <= vgafb_pkg::RST_ZERO;
      compare_colour_ff <= vgafb_pkg::RST_ZERO;
      rotate_count_ff <= vgafb_pkg::RST_ZERO;
      read_plane_choice_ff <= vgafb_pkg::RST_ZERO;
      rw_mode_reg_ff <= vgafb_pkg::RST_ZERO;
      misc_map_reg_ff <= vgafb_pkg::RST_ZERO;
      compare_ignore_reg_ff <= vgafb_pkg::RST_ZERO;
      write_mask_reg_ff <= vgafb_pkg::RST_WRITE_MASK;
      ext_mapping_reg_ff <= vgafb_pkg::RST_ZERO;
      page_select_reg_ff <= vgafb_pkg::RST_ZERO;
    end
    else if (data_wr)
    begin
      case (index_ff)
        vgafb_pkg::IDX_SET_RESET: set_reset_value_ff <= data_wdata;
        vgafb_pkg::IDX_SR_ENABLE: set_reset_enable_ff <= data_wdata;
        vgafb_pkg::IDX_COMPARE: compare_colour_ff <= data_wdata;
        vgafb_pkg::IDX_ROTATE: rotate_count_ff <= data_wdata;
        vgafb_pkg::IDX_READ_PLANE: read_plane_choice_ff <= data_wdata;
        vgafb_pkg::IDX_RW_MODE: rw_mode_reg_ff <= data_wdata;
        vgafb_pkg::IDX_MISC_MAP: misc_map_reg_ff <= data_wdata;
        vgafb_pkg::IDX_COMPARE_IGNORE: compare_ignore_reg_ff <= data_wdata;
        vgafb_pkg::IDX_WRITE_MASK: write_mask_reg_ff <= data_wdata;
        vgafb_pkg::IDX_EXT_MAPPING: ext_mapping_reg_ff <= data_wdata;
        vgafb_pkg::IDX_PAGE_SELECT: page_select_reg_ff <= data_wdata;
        default: ;
      endcase
    end
  end

  // Scratch bytes only store; nothing reads them but software
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < vgafb_pkg::SCRATCH_COUNT; i++)
    begin
      if (srst)
        scratch_ff[i] <= vgafb_pkg::RST_ZERO;
      else if (data_wr && is_scratch && (scratch_sel == 4'(i)))
        scratch_ff[i] <= data_wdata;
    end
  end

  //--------------------------------------------------------------
  // Register read-back
  //--------------------------------------------------------------
  logic [7:0] reg_rd_mux;
  always_comb
  begin
    case (index_ff)
      vgafb_pkg::IDX_SET_RESET: reg_rd_mux = set_reset_value_ff
                                             & vgafb_pkg::LOW_NIBBLE_MASK;
      vgafb_pkg::IDX_SR_ENABLE: reg_rd_mux = set_reset_enable_ff
                                             & vgafb_pkg::LOW_NIBBLE_MASK;
      vgafb_pkg::IDX_COMPARE: reg_rd_mux = compare_colour_ff
                                           & vgafb_pkg::LOW_NIBBLE_MASK;
      vgafb_pkg::IDX_ROTATE: reg_rd_mux = rotate_count_ff;
      vgafb_pkg::IDX_READ_PLANE: reg_rd_mux = read_plane_choice_ff & 8'h03;
      vgafb_pkg::IDX_RW_MODE: reg_rd_mux = rw_mode_reg_ff
                                           & vgafb_pkg::RW_MODE_MASK;
      vgafb_pkg::IDX_MISC_MAP: reg_rd_mux = misc_map_reg_ff
                                 & vgafb_pkg::LOW_NIBBLE_MASK;
      vgafb_pkg::IDX_COMPARE_IGNORE: reg_rd_mux = compare_ignore_reg_ff
                                 & vgafb_pkg::LOW_NIBBLE_MASK;
      vgafb_pkg::IDX_WRITE_MASK: reg_rd_mux = write_mask_reg_ff;
      vgafb_pkg::IDX_EXT_MAPPING: reg_rd_mux = ext_mapping_reg_ff
                                               & vgafb_pkg::EXT_MAPPING_MASK;
      vgafb_pkg::IDX_PAGE_SELECT: reg_rd_mux = page_select_reg_ff;
      default: reg_rd_mux = is_scratch ? scratch_ff[scratch_sel] : 8'h00;
    endcase
  end
  assign data_rdata = reg_rd_mux;
  assign idx_rdata = index_ff;

  //--------------------------------------------------------------
  // Mode fields
  //--------------------------------------------------------------
  wire odd_even = rw_mode_reg_ff[vgafb_pkg::RW_ODD_EVEN_BIT];
  wire read_mode1 = rw_mode_reg_ff[vgafb_pkg::RW_READ_MODE_BIT];
  wire [1:0] wmode = rw_mode_reg_ff[1:0];
  wire [1:0] map_sel = misc_map_reg_ff[vgafb_pkg::MISC_MAP_LSB +: 2];
  wire chain_oe = misc_map_reg_ff[vgafb_pkg::MISC_CHAIN_BIT];
  wire page_on = ext_mapping_reg_ff[vgafb_pkg::EXT_PAGE_BIT];
  wire linear_on = ext_mapping_reg_ff[vgafb_pkg::EXT_LINEAR_BIT];
  wire packed_on = ext_mapping_reg_ff[vgafb_pkg::EXT_PACKED_BIT];
  wire memmap_sel = ext_mapping_reg_ff[vgafb_pkg::EXT_MEMMAP_BIT];
  wire local_on = ext_mapping_reg_ff[vgafb_pkg::EXT_LOCAL_BIT];

  //--------------------------------------------------------------
  // Window decode
  //--------------------------------------------------------------
  wire [19:0] a = fb_req.addr;
  wire in_a0_all = (a >= vgafb_pkg::WIN_A0_BASE)
                   && (a <= vgafb_pkg::WIN_A0_LAST);
  wire in_a0_64k = (a >= vgafb_pkg::WIN_A0_BASE)
                   && (a <= vgafb_pkg::WIN_A0_64K_LAST);
  wire in_b0 = (a >= vgafb_pkg::WIN_B0_BASE) && (a <= vgafb_pkg::WIN_B0_LAST);
  wire in_b8 = (a >= vgafb_pkg::WIN_B8_BASE) && (a <= vgafb_pkg::WIN_B8_LAST);
  logic win_hit;
  always_comb
  begin
    case (map_sel)
      2'h0: win_hit = in_a0_all;
      2'h1: win_hit = in_a0_64k;
      2'h2: win_hit = in_b0;
      2'h3: win_hit = in_b8;
      default: win_hit = 1'b0;
    endcase
  end
  wire access = (fb_req.rd || fb_req.wr) && win_hit;

  //--------------------------------------------------------------
  // Routing: planar, bypass or local memory
  //--------------------------------------------------------------
  wire xlate_std = ({packed_on, linear_on, page_on} == 3'b000);
  wire paged = page_on && (linear_on || packed_on) && in_a0_64k;
  wire to_local = paged && local_on && !memmap_sel;
  vgafb_pkg::vgafb_route_t route;
  always_comb
  begin
    if (!access)
      route = vgafb_pkg::VGAFB_ROUTE_NONE;
    else if (xlate_std)
      route = vgafb_pkg::VGAFB_ROUTE_PLANAR;
    else if (to_local)
      route = vgafb_pkg::VGAFB_ROUTE_LOCAL;
    else
      route = vgafb_pkg::VGAFB_ROUTE_BYPASS;
  end

  // Page bits above host word address; offset from the A0000h base otherwise
  wire [15:0] off16 = a[15:0];
  wire [EXT_ADDR_W-1:0] paged_addr =
    EXT_ADDR_W'({page_select_reg_ff[6:0], off16[15:2], 2'b00})
    | EXT_ADDR_W'(off16[1:0]);
  wire [EXT_ADDR_W-1:0] flat_addr = EXT_ADDR_W'(a - vgafb_pkg::WIN_A0_BASE);
  assign bypass_valid = (route == vgafb_pkg::VGAFB_ROUTE_BYPASS)
                        || (route == vgafb_pkg::VGAFB_ROUTE_LOCAL);
  assign bypass_wr = fb_req.wr;
  assign bypass_local = (route == vgafb_pkg::VGAFB_ROUTE_LOCAL);
  assign bypass_addr = paged ? paged_addr : flat_addr;
  assign bypass_prefetch = 1'b0;
  assign bypass_need_table = 1'b0;
  assign mmio_page = page_select_reg_ff;

  //--------------------------------------------------------------
  // Plane addressing
  //--------------------------------------------------------------
  wire planar = (route == vgafb_pkg::VGAFB_ROUTE_PLANAR);
  wire oe_steer = odd_even || chain_oe;
  // Offset shifted down past A0, with the top bit of the window offset on top
  wire [PLANE_ADDR_W-1:0] chain_addr =
    PLANE_ADDR_W'({flat_addr[16], flat_addr[15:1]});
  assign plane_addr = oe_steer ? chain_addr
                               : PLANE_ADDR_W'(flat_addr[15:0]);
  wire [3:0] oe_planes = a[0] ? 4'b1010 : 4'b0101;
  wire [3:0] planes_sel = oe_steer ? (oe_planes & plane_write_mask)
                                   : plane_write_mask;
  assign plane_rd = planar && fb_req.rd;

  //--------------------------------------------------------------
  // Per-plane datapath
  //--------------------------------------------------------------
  wire [2:0] rot = rotate_count_ff[2:0];
  wire [15:0] rot_dbl = {fb_req.wdata, fb_req.wdata} >> rot;
  wire [7:0] rotated = rot_dbl[7:0];
  wire [31:0] wr_bytes;
  wire [31:0] cmp_bytes;

  for (genvar p = 0; p < 4; p++)
  begin : g_plane
    vgafb_plane_lane u_lane (
      .wmode(wmode),
      .rotated(rotated),
      .bit_mask(write_mask_reg_ff),
      .host_data(fb_req.wdata),
      .colour_bit(fb_req.wdata[p]),
      .sr_value(set_reset_value_ff[p]),
      .sr_enable(set_reset_enable_ff[p]),
      .latch(latch_ff[8*p +: 8]),
      .plane_byte(plane_rdata[8*p +: 8]),
      .cmp_colour(compare_colour_ff[p]),
      .cmp_include(compare_ignore_reg_ff[p]),
      .wr_byte(wr_bytes[8*p +: 8]),
      .cmp_match(cmp_bytes[8*p +: 8])
    );
  end

  assign plane_wr.plane_en = (planar && fb_req.wr) ? planes_sel : 4'h0;
  assign plane_wr.data = wr_bytes;

  // In odd/even the read plane follows A0 within the chosen pair
  wire [1:0] rd_plane = oe_steer
    ? {read_plane_choice_ff[1], a[0]} : read_plane_choice_ff[1:0];
  wire [7:0] mode0_byte = plane_rdata[8*rd_plane +: 8];
  wire [7:0] mode1_byte = cmp_bytes[7:0] & cmp_bytes[15:8]
                          & cmp_bytes[23:16] & cmp_bytes[31:24];
  wire [7:0] rd_result = read_mode1 ? mode1_byte : mode0_byte;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      latch_ff <= 32'h0;
    else if (plane_rd)
      latch_ff <= plane_rdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      fb_rdata_ff <= 8'h00;
      fb_hit_ff <= 1'b0;
    end
    else
    begin
      fb_rdata_ff <= plane_rd ? rd_result : fb_rdata_ff;
      fb_hit_ff <= access;
    end
  end
  assign fb_rdata = fb_rdata_ff;
  assign fb_hit = fb_hit_ff;
endmodule

// ===== vgafb_pkg.sv
// Purpose: Shared constants and types for the frame-buffer access block
// Assumes: Indexed graphics registers reached through an index/data port
// Notes: Index values are the register numbers seen by software
package vgafb_pkg;
  // Register indexes
  localparam logic [7:0] IDX_SET_RESET = 8'h00;
  localparam logic [7:0] IDX_SR_ENABLE = 8'h01;
  localparam logic [7:0] IDX_COMPARE = 8'h02;
  localparam logic [7:0] IDX_ROTATE = 8'h03;
  localparam logic [7:0] IDX_READ_PLANE = 8'h04;
  localparam logic [7:0] IDX_RW_MODE = 8'h05;
  localparam logic [7:0] IDX_MISC_MAP = 8'h06;
  localparam logic [7:0] IDX_COMPARE_IGNORE = 8'h07;
  localparam logic [7:0] IDX_WRITE_MASK = 8'h08;
  localparam logic [7:0] IDX_EXT_MAPPING = 8'h10;
  localparam logic [7:0] IDX_PAGE_SELECT = 8'h11;
  localparam logic [7:0] IDX_SCRATCH_FIRST = 8'h14;
  localparam logic [7:0] IDX_SCRATCH_LAST = 8'h1f;
  localparam int SCRATCH_COUNT = 12;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_WRITE_MASK = 8'hff;
  // Field positions
  localparam int RW_ODD_EVEN_BIT = 4;
  localparam int RW_READ_MODE_BIT = 3;
  localparam int MISC_MAP_LSB = 2;
  localparam int MISC_CHAIN_BIT = 1;
  localparam int EXT_PAGE_BIT = 0;
  localparam int EXT_LINEAR_BIT = 1;
  localparam int EXT_PACKED_BIT = 2;
  localparam int EXT_MEMMAP_BIT = 3;
  localparam int EXT_LOCAL_BIT = 4;
  // Reserved-bit read masks
  localparam logic [7:0] RW_MODE_MASK = 8'hfb;
  localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0f;
  localparam logic [7:0] EXT_MAPPING_MASK = 8'h1f;
  // Host windows
  localparam logic [19:0] WIN_A0_BASE = 20'ha0000;
  localparam logic [19:0] WIN_A0_LAST = 20'hbffff;
  localparam logic [19:0] WIN_A0_64K_LAST = 20'haffff;
  localparam logic [19:0] WIN_B0_BASE = 20'hb0000;
  localparam logic [19:0] WIN_B0_LAST = 20'hb7fff;
  localparam logic [19:0] WIN_B8_BASE = 20'hb8000;
  localparam logic [19:0] WIN_B8_LAST = 20'hbffff;

  typedef enum logic [1:0] {
    VGAFB_WM_ROTATE,
    VGAFB_WM_LATCH,
    VGAFB_WM_COLOUR,
    VGAFB_WM_MASKED
  } vgafb_wmode_t;

  typedef enum logic [1:0] {
    VGAFB_ROUTE_NONE,
    VGAFB_ROUTE_PLANAR,
    VGAFB_ROUTE_BYPASS,
    VGAFB_ROUTE_LOCAL
  } vgafb_route_t;

  // Frame-buffer request from the host
  typedef struct packed {
    logic rd;
    logic wr;
    logic [19:0] addr;
    logic [7:0] wdata;
  } vgafb_req_t;

  // Plane-side write
  typedef struct packed {
    logic [3:0] plane_en;
    logic [31:0] data;
  } vgafb_pwr_t;
endpackage

// ===== vgafb_plane_lane.sv
// Purpose: Write-data and compare path for one memory plane
// Assumes: Mode decode done by the caller
// Notes: Instantiated once per plane
`timescale 1ns/1ps
module vgafb_plane_lane
(
  input wire logic [1:0] wmode,
  input wire logic [7:0] rotated,
  input wire logic [7:0] bit_mask,
  input wire logic [7:0] host_data,
  input wire logic colour_bit,
  input wire logic sr_value,
  input wire logic sr_enable,
  input wire logic [7:0] latch,
  input wire logic [7:0] plane_byte,
  input wire logic cmp_colour,
  input wire logic cmp_include,
  output logic [7:0] wr_byte,
  output logic [7:0] cmp_match
);
  wire [7:0] sr_byte = {8{sr_value}};
  wire [7:0] wm0_src = sr_enable ? sr_byte : rotated;
  wire [7:0] wm3_mask = host_data & bit_mask;

  always_comb
  begin
    case (wmode)
      2'h0: wr_byte = (wm0_src & bit_mask) | (latch & ~bit_mask);
      2'h1: wr_byte = latch;
      2'h2: wr_byte = ({8{colour_bit}} & bit_mask)
                      | (latch & ~bit_mask);
      2'h3: wr_byte = (sr_byte & wm3_mask) | (latch & ~wm3_mask);
      default: wr_byte = latch;
    endcase
  end

  // Excluded planes always match
  assign cmp_match = cmp_include ? ~(plane_byte ^ {8{cmp_colour}})
                                 : 8'hff;
endmodule

// ===== vgafb_access_sva.sv
// Purpose: Port-level checks for the frame-buffer access block
// Assumes: Bound to every vgafb_access instance
// Notes: Ties plane and bypass activity to host requests
`timescale 1ns/1ps
module vgafb_access_sva
#(
  parameter int PLANE_ADDR_W = 16,
  parameter int EXT_ADDR_W = 23
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic data_wr,
  input wire vgafb_pkg::vgafb_req_t fb_req,
  input wire logic fb_hit,
  input wire logic [7:0] fb_rdata,
  input wire logic plane_rd,
  input wire vgafb_pkg::vgafb_pwr_t plane_wr,
  input wire logic bypass_valid,
  input wire logic bypass_wr,
  input wire logic bypass_local,
  input wire logic bypass_prefetch,
  input wire logic bypass_need_table,
  input wire logic [7:0] mmio_page
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // --------
  // Request sequences
  // --------
  sequence s_plane_read;
    fb_req.rd && plane_rd;
  endsequence
  sequence s_bypass_cycle;
    (fb_req.rd || fb_req.wr) && bypass_valid;
  endsequence
  sequence s_idle;
    !fb_req.rd && !fb_req.wr;
  endsequence
  // --------
  // Assertions
  // --------
  plane_read_hit_a: assert property (
    s_plane_read |=> fb_hit) else $error("planar read gave no hit");
  bypass_hit_a: assert property (
    s_bypass_cycle |=> fb_hit) else $error("bypass cycle gave no hit");
  idle_no_hit_a: assert property (
    s_idle |=> !fb_hit) else $error("hit without a request");
  read_needs_req_a: assert property (
    plane_rd |-> fb_req.rd && !bypass_valid)
    else $error("plane read without planar request");
  latch_hold_a: assert property (
    !plane_rd |=> $stable(fb_rdata)) else $error("read data moved idle");
  write_needs_req_a: assert property (
    |plane_wr.plane_en |-> fb_req.wr && !bypass_valid)
    else $error("plane write without planar write");
  no_prefetch_a: assert property (
    !bypass_prefetch && !bypass_need_table) else $error("prefetch raised");
  page_write_only_a: assert property (
    $changed(mmio_page) |-> $past(data_wr) || $past(srst))
    else $error("page changed without register write");
  local_in_bypass_a: assert property (
    bypass_local |-> bypass_valid) else $error("local route outside bypass");
  bypass_dir_a: assert property (
    bypass_valid |-> (fb_req.rd || fb_req.wr) && bypass_wr == fb_req.wr)
    else $error("bypass direction wrong");
endmodule
bind vgafb_access vgafb_access_sva #(
  .PLANE_ADDR_W(PLANE_ADDR_W),
  .EXT_ADDR_W(EXT_ADDR_W)
) u_sva (
  .clk_sys(clk_sys),
  .srst(srst),
  .data_wr(data_wr),
  .fb_req(fb_req),
  .fb_hit(fb_hit),
  .fb_rdata(fb_rdata),
  .plane_rd(plane_rd),
  .plane_wr(plane_wr),
  .bypass_valid(bypass_valid),
  .bypass_wr(bypass_wr),
  .bypass_local(bypass_local),
  .bypass_prefetch(bypass_prefetch),
  .bypass_need_table(bypass_need_table),
  .mmio_page(mmio_page)
);

// ===== vgafb_plane_model.sv
// Purpose: Four memory planes behind the access block
// Assumes: Read data same cycle, writes on the clock edge
// Notes: Only the low address byte is stored
`timescale 1ns/1ps
module vgafb_plane_model
(
  input wire logic clk_sys,
  input wire logic [15:0] plane_addr,
  input wire logic plane_rd,
  input wire vgafb_pkg::vgafb_pwr_t plane_wr,
  output logic [31:0] plane_rdata
);
  logic [31:0] mem [0:255];
  logic [31:0] last_ff = 32'h0;
  logic [7:0] slot;
  assign slot = plane_addr[7:0];
  // Idle bus shows inverted stale data
  assign plane_rdata = plane_rd ? mem[slot] : ~last_ff;
  always @(posedge clk_sys)
  begin
    if (plane_rd)
      last_ff <= mem[slot];
    for (int p = 0; p < 4; p++)
      if (plane_wr.plane_en[p])
        mem[slot][8*p +: 8] <= plane_wr.data[8*p +: 8];
  end
  task automatic preload(input logic [7:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask
endmodule

// ===== tb_vgafb_access.sv
// Purpose: Self-checking bench for the frame-buffer access block
// Assumes: Plane model behind, host cycles driven here
// Notes: Mapping value 001 is never programmed
`timescale 1ns/1ps
module tb_vgafb_access;
  typedef struct packed {
    logic [7:0] misc;
    logic [19:0] addr;
    logic hit;
  } vgafb_row_t;
  logic clk_sys, srst, idx_wr, data_wr, data_rd, fb_hit, plane_rd;
  logic bypass_valid, bypass_wr, bypass_local, bypass_prefetch;
  logic bypass_need_table, c_rd, c_bv, c_loc, c_hit;
  logic [7:0] idx_wdata, data_wdata, data_rdata, idx_rdata, fb_rdata;
  logic [7:0] mmio_page, c_rdata, v;
  logic [3:0] plane_write_mask, c_en;
  logic [15:0] plane_addr, c_paddr;
  logic [31:0] plane_rdata, c_data;
  logic [22:0] bypass_addr, c_baddr;
  vgafb_pkg::vgafb_req_t fb_req;
  vgafb_pkg::vgafb_pwr_t plane_wr;
  int n_mismatch, check_count, cycles;
  vgafb_row_t rows [12] = '{
    '{8'h00, 20'ha0000, 1'b1}, '{8'h00, 20'hbffff, 1'b1},
    '{8'h00, 20'h9ffff, 1'b0}, '{8'h00, 20'hc0000, 1'b0},
    '{8'h04, 20'haffff, 1'b1}, '{8'h04, 20'hb0000, 1'b0},
    '{8'h08, 20'hb0000, 1'b1}, '{8'h08, 20'hb7fff, 1'b1},
    '{8'h08, 20'hb8000, 1'b0}, '{8'h08, 20'ha0000, 1'b0},
    '{8'h0c, 20'hb8000, 1'b1}, '{8'h0c, 20'hb7fff, 1'b0}};
  vgafb_access dut (.clk_sys(clk_sys), .srst(srst), .idx_wr(idx_wr),
    .idx_wdata(idx_wdata), .data_wr(data_wr), .data_rd(data_rd),
    .data_wdata(data_wdata), .data_rdata(data_rdata),
    .idx_rdata(idx_rdata), .fb_req(fb_req), .fb_hit(fb_hit),
    .fb_rdata(fb_rdata), .plane_addr(plane_addr), .plane_rd(plane_rd),
    .plane_wr(plane_wr), .plane_rdata(plane_rdata),
    .bypass_valid(bypass_valid), .bypass_wr(bypass_wr),
    .bypass_local(bypass_local), .bypass_addr(bypass_addr),
    .bypass_prefetch(bypass_prefetch),
    .bypass_need_table(bypass_need_table),
    .plane_write_mask(plane_write_mask), .mmio_page(mmio_page));
  vgafb_plane_model u_mem (.clk_sys(clk_sys), .plane_addr(plane_addr),
    .plane_rd(plane_rd), .plane_wr(plane_wr), .plane_rdata(plane_rdata));
  // --------
  // Helpers
  // --------
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic set_idx(input logic [7:0] i);
    @(posedge clk_sys);
    idx_wr <= 1'b1;
    idx_wdata <= i;
    @(posedge clk_sys);
    idx_wr <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    set_idx(i);
    data_wr <= 1'b1;
    data_wdata <= d;
    @(posedge clk_sys);
    data_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] i);
    set_idx(i);
    #1;
    v = data_rdata;
  endtask
  task automatic fb(input logic rd, input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    fb_req <= '{rd: rd, wr: !rd, addr: a, wdata: d};
    @(negedge clk_sys);
    c_rd = plane_rd;
    c_en = plane_wr.plane_en;
    c_data = plane_wr.data;
    c_paddr = plane_addr;
    c_bv = bypass_valid;
    c_loc = bypass_local;
    c_baddr = bypass_addr;
    @(posedge clk_sys);
    fb_req <= '0;
    #1;
    c_hit = fb_hit;
    c_rdata = fb_rdata;
  endtask
  function automatic logic [31:0] wexp(input logic [1:0] m,
    input logic [7:0] d, input logic [7:0] msk, input logic [3:0] sr,
    input logic [3:0] sre, input logic [2:0] rot, input logic [31:0] lat);
    logic [7:0] r, q, k;
    r = (d >> rot) | (d << (8 - rot));
    for (int p = 0; p < 4; p++)
    begin
      k = msk;
      case (m)
        2'd0: q = sre[p] ? {8{sr[p]}} : r;
        2'd1: q = lat[8*p +: 8];
        2'd2: q = {8{d[p]}};
        default:
        begin
          k = d & msk;
          q = {8{sr[p]}};
        end
      endcase
      wexp[8*p +: 8] = (q & k) | (lat[8*p +: 8] & ~k);
    end
  endfunction
  task automatic wcase(input logic [1:0] m, input logic [7:0] d,
    input logic [7:0] msk, input logic [3:0] sr, input logic [3:0] sre,
    input logic [2:0] rot);
    reg_wr(8'h00, {4'h0, sr});
    reg_wr(8'h01, {4'h0, sre});
    reg_wr(8'h03, {5'h0, rot});
    reg_wr(8'h08, msk);
    reg_wr(8'h05, {6'h0, m});
    fb(1'b0, 20'ha0031, d);
    chk_val("plane enables", plane_write_mask, c_en);
    chk_val("plane data", wexp(m, d, msk, sr, sre, rot, 32'hc3a55a3c),
      c_data);
  endtask
  task automatic bcase(input logic [7:0] e, input logic [19:0] a,
    input logic [22:0] ea, input logic el);
    reg_wr(8'h10, e);
    fb(1'b1, a, 8'h00);
    chk_val("bypass valid", 1'b1, c_bv);
    chk_val("planar idle", 1'b0, c_rd);
    chk_val("bypass addr", ea, c_baddr);
    chk_val("local route", el, c_loc);
  endtask
  // --------
  // Clock, timeout, sequence
  // --------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    {srst, idx_wr, data_wr, data_rd, idx_wdata, data_wdata} = 20'h80000;
    fb_req = '0;
    plane_write_mask = 4'hf;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      reg_wr(8'h06, rows[i].misc);
      fb(1'b1, rows[i].addr, 8'h00);
      chk_val("window hit", rows[i].hit, c_hit);
    end
    reg_rd(8'h08);
    chk_val("mask reset", 8'hff, v);
    reg_rd(8'h10);
    chk_val("mapping reset", 8'h00, v);
    for (int i = 8'h14; i <= 8'h1f; i++)
    begin
      reg_rd(i[7:0]);
      chk_val("flag reset", 8'h00, v);
      chk_val("index", i, idx_rdata);
      reg_wr(i[7:0], 8'ha5 ^ i[7:0]);
      reg_rd(i[7:0]);
      chk_val("flag value", 8'ha5 ^ i[7:0], v);
    end
    for (int i = 6; i < 10; i++)
    begin
      reg_wr(i[7:0], 8'hff);
      reg_rd(i[7:0]);
      chk_val("readback", i < 8 ? 8'h0f : 8'hff >> (8 * (i - 8)), v);
    end
    reg_wr(8'h06, 8'h00);
    u_mem.preload(8'h10, 32'h44332211);
    for (int p = 0; p < 4; p++)
    begin
      reg_wr(8'h04, p[7:0]);
      fb(1'b1, 20'ha0010, 8'h00);
      chk_val("plane byte", 8'h11 * (p + 1), c_rdata);
    end
    chk_val("plane addr", 16'h0010, c_paddr);
    u_mem.preload(8'h20, 32'hf00fcc5a);
    reg_wr(8'h02, 8'h05);
    reg_wr(8'h05, 8'h08);
    for (int g = 0; g < 3; g++)
    begin
      reg_wr(8'h07, 8'h0f >> (2 * g));
      fb(1'b1, 20'ha0020, 8'h00);
      chk_val("colour match", cexp(g), c_rdata);
    end
    u_mem.preload(8'h30, 32'hc3a55a3c);
    fb(1'b1, 20'ha0030, 8'h00);
    wcase(2'd0, 8'h96, 8'hff, 4'h0, 4'h0, 3'd3);
    wcase(2'd0, 8'h81, 8'h0f, 4'h4, 4'h5, 3'd0);
    wcase(2'd1, 8'h00, 8'hff, 4'h0, 4'h0, 3'd0);
    wcase(2'd2, 8'h0a, 8'h3c, 4'h0, 4'h0, 3'd0);
    wcase(2'd3, 8'hf0, 8'h3c, 4'h5, 4'h0, 3'd0);
    plane_write_mask <= 4'h6;
    wcase(2'd0, 8'h3c, 8'hff, 4'h0, 4'h0, 3'd0);
    plane_write_mask <= 4'hf;
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(8'h05, k[1] ? 8'h00 : 8'h10);
      reg_wr(8'h06, k[1] ? 8'h02 : 8'h00);
      fb(1'b0, 20'ha0040 + k[0], 8'h00);
      chk_val("odd even planes", k[0] ? 4'ha : 4'h5, c_en);
    end
    reg_wr(8'h06, 8'h00);
    reg_wr(8'h11, 8'h05);
    #1;
    chk_val("page out", 8'h05, mmio_page);
    bcase(8'h03, 20'ha1234, 23'h051234, 1'b0);
    bcase(8'h03, 20'hb8010, 23'h018010, 1'b0);
    bcase(8'h13, 20'ha1234, 23'h051234, 1'b1);
    bcase(8'h1b, 20'ha1234, 23'h051234, 1'b0);
    bcase(8'h15, 20'ha1234, 23'h051234, 1'b1);
    bcase(8'h04, 20'ha1234, 23'h001234, 1'b0);
    bcase(8'h02, 20'hb0010, 23'h010010, 1'b0);
    reg_wr(8'h11, 8'h00);
    bcase(8'h17, 20'ha1234, 23'h001234, 1'b1);
    reg_wr(8'h10, 8'h00);
    fb(1'b1, 20'ha0010, 8'h00);
    chk_val("planar again", {1'b1, 1'b0}, {c_rd, c_bv});
    reg_wr(8'h11, 8'h33);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    chk_val("page after reset", 8'h00, mmio_page);
    results();
  end
  function automatic logic [7:0] cexp(input int g);
    logic [3:0] ign;
    ign = 4'hf >> (2 * g);
    cexp = 8'hff;
    for (int p = 0; p < 4; p++)
      if (ign[p])
        cexp &= ~(32'hf00fcc5a >> (8 * p) ^ {8{p[0] ? 1'b0 : 1'b1}});
  endfunction
endmodule
